// [hdl/spms_pkg.sv]
// Purpose: constants for the sensor power mode sequencer
// Assumes: APB slave, 32-bit data, 50 MHz clock
// Notes: register map offsets are byte addresses
//
// Behaviour
// RULE1: sleep mode runs no conversions and keeps the sequencer idle.
// RULE2: normal mode repeats measurement then standby until mode changes.
// RULE3: forced mode runs one measurement then returns to sleep.
// RULE4: mode 00 sleep, 01 and 10 forced, 11 normal.
// RULE5: after reset the device sits in sleep mode.
// RULE6: reset restores every register to its reset value; soft reset leaves cal_reg, pdat_reg, tdat_reg and evt_cnt_reg unchanged.
// RULE7: all registers stay readable and writable in sleep.
// RULE8: host rewrites forced mode for each further single-shot result.
// RULE9: reset-detected flag bit 0 set on reset completion, cleared on read.
// RULE10: normal sampling period is prescaler over 200 Hz base rate.
// RULE11: normal mode updates data registers automatically each result.
// RULE12: mode change written during measurement waits until it ends.
// RULE13: further mode writes ignored while a change is pending.
// RULE14: unsupported transitions are ignored, mode stays.
// RULE15: measurement does temperature then pressure, then optional IIR filter.
// RULE16: pressure conversion runs only when power control bit 0 set.
// RULE17: pressure oversampling 000..101 gives x1..x32, 16..21 bits, extra byte.
// RULE18: IIR coefficient selectable from 0 bypass to 127.
// RULE19: temperature runs only when bit 1 set; its oversampling at 5:3.
// RULE20: filter resets on filter write, enable fall, or sleep to normal.
// RULE21: filtered = (old * coeff + sample) / (coeff + 1).
// RULE22: after forced completes, mode field reads sleep.
// RULE23: skipped channels keep their data registers unchanged.
package spms_pkg;
  localparam logic [7:0] ADDR_PWR = 8'h00;
  localparam logic [7:0] ADDR_OSR = 8'h04;
  localparam logic [7:0] ADDR_ODR = 8'h08;
  localparam logic [7:0] ADDR_IIR = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_EVT = 8'h14;
  localparam logic [7:0] ADDR_PDAT = 8'h18;
  localparam logic [7:0] ADDR_TDAT = 8'h1C;
  localparam logic [7:0] ADDR_ID = 8'h20;
  localparam logic [7:0] ADDR_CAL = 8'h24;
  localparam int PRESS_EN_BIT = 0;
  localparam int TEMP_EN_BIT = 1;
  localparam int MODE_LSB = 4;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [2:0] OSR_MAX = 3'h5;
  localparam logic [4:0] ODR_MAX = 5'h11;
  localparam logic [6:0] IIR_MAX = 7'h7F;
  localparam logic [7:0] ID_VALUE = 8'h5A; // arbitrary value
  localparam int CLK_HZ = 50000000;
  localparam int BASE_HZ = 200;
  localparam int BASE_CYC = CLK_HZ / BASE_HZ;
  localparam int CONV_CYC_X1 = 64;
  localparam int DATA_W = 24;
  typedef enum logic [2:0] {
    SPMS_IDLE = 3'b000,
    SPMS_TEMP = 3'b001,
    SPMS_PRES = 3'b011,
    SPMS_FILT = 3'b010,
    SPMS_STBY = 3'b110
  } spms_state_e;
endpackage : spms_pkg

// [hdl/spms_conv.sv]
// Purpose: stand-in converter that counts one oversampled conversion
// Assumes: start is a pulse while idle
// Notes: sample value comes from the analog front end input
`timescale 1ns/1ps
`default_nettype none
module spms_conv (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [2:0] osr_i,
  input wire logic [spms_pkg::DATA_W-1:0] adc_i,
  output logic done_o,
  output logic [spms_pkg::DATA_W-1:0] data_o
);
  logic [31:0] cnt_reg;
  logic busy_reg;
  // oversampling doubles conversion time and adds one result bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
      data_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= 32'(spms_pkg::CONV_CYC_X1) << osr_i;
      end else if (busy_reg) begin
        if (cnt_reg <= 32'h0000_0001) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
          // keep 16 + osr significant bits, rest in extra-low byte
          data_o <= adc_i & ~(24'hFF_FFFF >> (5'd16 + 5'(osr_i))); // RULE17
        end else begin
          cnt_reg <= cnt_reg - 32'h0000_0001;
        end
      end
    end
  end
endmodule : spms_conv
`default_nettype wire

// [hdl/spms_iir.sv]
// Purpose: first-order IIR filter on one channel
// Assumes: coefficient 0 bypasses
// Notes: integer division, one cycle per sample
`timescale 1ns/1ps
`default_nettype none
module spms_iir (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [6:0] coef_i,
  input wire logic [spms_pkg::DATA_W-1:0] sample_i,
  output logic [spms_pkg::DATA_W-1:0] filt_o
);
  logic primed_reg;
  logic [31:0] acc;
  always_comb begin
    acc = 32'(filt_o) * 32'(coef_i) + 32'(sample_i);
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      primed_reg <= 1'b0;
      filt_o <= '0;
    end else if (load_i) begin
      // a clear in the same cycle still lets this sample through as the seed
      primed_reg <= 1'b1;
      if (clear_i || !primed_reg || coef_i == 7'h00) begin
        filt_o <= sample_i; // RULE20
      end else begin
        filt_o <= 24'(acc / (32'(coef_i) + 32'h0000_0001)); // RULE21
      end
    end else if (clear_i) begin
      primed_reg <= 1'b0; // RULE20
    end
  end
endmodule : spms_iir
`default_nettype wire

// [hdl/spms_top.sv]
// Purpose: power mode sequencer with APB register access
// Assumes: single 50 MHz clock, rstn_i from power-on reset generator
// Notes: zero wait state APB slave, pslverr on unmapped address
`timescale 1ns/1ps
`default_nettype none
module spms_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic soft_rst_i,
  input wire logic [spms_pkg::DATA_W-1:0] adc_temp_i,
  input wire logic [spms_pkg::DATA_W-1:0] adc_press_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  output logic meas_busy_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic press_en_reg;
  logic temp_en_reg;
  logic [1:0] mode_reg;
  logic [1:0] pend_mode_reg;
  logic pend_reg;
  logic [2:0] osr_p_reg;
  logic [2:0] osr_t_reg;
  logic [4:0] odr_reg;
  logic [6:0] iir_reg;
  logic por_flag_reg;
  logic [31:0] cal_reg;
  logic [spms_pkg::DATA_W-1:0] pdat_reg;
  logic [spms_pkg::DATA_W-1:0] tdat_reg;
  logic [31:0] evt_cnt_reg;
  spms_pkg::spms_state_e state_reg;
  // wide enough for the base period shifted by the largest prescaler exponent
  logic [39:0] stby_cnt_reg;
  logic [1:0] srst_sync_reg;
  logic srst_prev_reg;
  logic iir_clr_reg;
  logic conv_start_reg;
  logic filt_load_reg;
  logic got_p_reg;
  logic got_t_reg;

  logic wr_acc;
  logic rd_acc;
  logic conv_done;
  logic [spms_pkg::DATA_W-1:0] conv_data;
  logic [spms_pkg::DATA_W-1:0] filt_p;
  logic [spms_pkg::DATA_W-1:0] filt_t;
  logic soft_rst;
  logic measuring;
  logic [2:0] conv_osr;
  logic [spms_pkg::DATA_W-1:0] conv_adc;

  function automatic logic is_forced(input logic [1:0] m);
    is_forced = (m == 2'b01) || (m == 2'b10); // RULE4
  endfunction : is_forced

  function automatic logic legal_move(input logic [1:0] from, input logic [1:0] to);
    // forced and normal are only entered from sleep; sleep always reachable
    legal_move = (to == spms_pkg::MODE_SLEEP) || (from == spms_pkg::MODE_SLEEP); // RULE14
  endfunction : legal_move

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign measuring = (state_reg == spms_pkg::SPMS_TEMP) || (state_reg == spms_pkg::SPMS_PRES)
                     || (state_reg == spms_pkg::SPMS_FILT);
  assign soft_rst = srst_sync_reg[1] && !srst_prev_reg;

  // ----------------------------------------------------------------
  // soft reset pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srst_sync_reg <= 2'b00;
      srst_prev_reg <= 1'b0;
    end else begin
      srst_sync_reg <= {srst_sync_reg[0], soft_rst_i};
      srst_prev_reg <= srst_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        // registers stay accessible in every mode, sleep included
        case (paddr_i) // RULE7
          spms_pkg::ADDR_PWR: prdata_o <= {26'h0, mode_reg, 2'b00, temp_en_reg, press_en_reg};
          spms_pkg::ADDR_OSR: prdata_o <= {26'h0, osr_t_reg, osr_p_reg};
          spms_pkg::ADDR_ODR: prdata_o <= {27'h0, odr_reg};
          spms_pkg::ADDR_IIR: prdata_o <= {25'h0, iir_reg};
          spms_pkg::ADDR_STAT: prdata_o <= {28'h0, pend_reg, measuring, 1'b0, por_flag_reg};
          spms_pkg::ADDR_EVT: prdata_o <= evt_cnt_reg;
          spms_pkg::ADDR_PDAT: prdata_o <= {8'h00, pdat_reg};
          spms_pkg::ADDR_TDAT: prdata_o <= {8'h00, tdat_reg};
          spms_pkg::ADDR_ID: prdata_o <= {24'h00_0000, spms_pkg::ID_VALUE};
          spms_pkg::ADDR_CAL: prdata_o <= cal_reg;
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      press_en_reg <= 1'b0; // RULE6
      temp_en_reg <= 1'b0;
      osr_p_reg <= 3'h0;
      osr_t_reg <= 3'h0;
      odr_reg <= 5'h00;
      iir_reg <= 7'h00;
      cal_reg <= 32'h0000_0000;
    end else if (soft_rst) begin
      press_en_reg <= 1'b0;
      temp_en_reg <= 1'b0;
      osr_p_reg <= 3'h0;
      osr_t_reg <= 3'h0;
      odr_reg <= 5'h00;
      iir_reg <= 7'h00;
    end else if (wr_acc && pready_o) begin
      case (paddr_i)
        spms_pkg::ADDR_PWR: begin
          press_en_reg <= pwdata_i[spms_pkg::PRESS_EN_BIT]; // RULE16
          temp_en_reg <= pwdata_i[spms_pkg::TEMP_EN_BIT]; // RULE19
        end
        spms_pkg::ADDR_OSR: begin
          // out-of-range oversampling clamps to the widest setting
          osr_p_reg <= (pwdata_i[2:0] > spms_pkg::OSR_MAX) ? spms_pkg::OSR_MAX : pwdata_i[2:0];
          osr_t_reg <= (pwdata_i[5:3] > spms_pkg::OSR_MAX) ? spms_pkg::OSR_MAX : pwdata_i[5:3];
        end
        spms_pkg::ADDR_ODR: odr_reg <= (pwdata_i[4:0] > spms_pkg::ODR_MAX) ? spms_pkg::ODR_MAX
                                       : pwdata_i[4:0];
        spms_pkg::ADDR_IIR: iir_reg <= pwdata_i[6:0] & spms_pkg::IIR_MAX; // RULE18
        spms_pkg::ADDR_CAL: cal_reg <= pwdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reset detected flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_flag_reg <= 1'b1; // RULE9
    end else if (soft_rst) begin
      por_flag_reg <= 1'b1; // RULE9
    end else if (rd_acc && pready_o && paddr_i == spms_pkg::ADDR_STAT) begin
      por_flag_reg <= 1'b0; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // filter reset: setting write, enable falling, sleep to normal
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      iir_clr_reg <= 1'b0;
    end else begin
      iir_clr_reg <= soft_rst
        || (wr_acc && pready_o && paddr_i == spms_pkg::ADDR_IIR)
        || (wr_acc && pready_o && paddr_i == spms_pkg::ADDR_PWR
            && ((press_en_reg && !pwdata_i[spms_pkg::PRESS_EN_BIT])
                || (temp_en_reg && !pwdata_i[spms_pkg::TEMP_EN_BIT])))
        || (mode_reg == spms_pkg::MODE_SLEEP && state_reg == spms_pkg::SPMS_IDLE && !pend_reg
            && wr_acc && pready_o && paddr_i == spms_pkg::ADDR_PWR
            && pwdata_i[spms_pkg::MODE_LSB +: 2] == spms_pkg::MODE_NORMAL); // RULE20
    end
  end

  // ----------------------------------------------------------------
  // mode control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= spms_pkg::MODE_SLEEP; // RULE5
      pend_reg <= 1'b0;
      pend_mode_reg <= spms_pkg::MODE_SLEEP;
    end else if (soft_rst) begin
      mode_reg <= spms_pkg::MODE_SLEEP;
      pend_reg <= 1'b0;
    end else if (state_reg == spms_pkg::SPMS_FILT && is_forced(mode_reg)) begin
      mode_reg <= pend_reg ? pend_mode_reg : spms_pkg::MODE_SLEEP; // RULE3 RULE22
      pend_reg <= 1'b0;
    end else if (pend_reg && !measuring) begin
      mode_reg <= pend_mode_reg; // RULE12
      pend_reg <= 1'b0;
    end else if (wr_acc && pready_o && paddr_i == spms_pkg::ADDR_PWR && !pend_reg) begin // RULE13
      if (legal_move(mode_reg, pwdata_i[spms_pkg::MODE_LSB +: 2])) begin // RULE14
        if (measuring) begin
          pend_reg <= 1'b1; // RULE12
          pend_mode_reg <= pwdata_i[spms_pkg::MODE_LSB +: 2];
        end else begin
          mode_reg <= pwdata_i[spms_pkg::MODE_LSB +: 2]; // RULE8
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= spms_pkg::SPMS_IDLE;
      stby_cnt_reg <= 40'h00_0000_0000;
      conv_start_reg <= 1'b0;
      filt_load_reg <= 1'b0;
      meas_busy_o <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      filt_load_reg <= 1'b0;
      meas_busy_o <= measuring;
      case (state_reg)
        spms_pkg::SPMS_IDLE: begin
          // idle in sleep: nothing is converted
          if (mode_reg != spms_pkg::MODE_SLEEP && !soft_rst && !pend_reg) begin // RULE1
            state_reg <= spms_pkg::SPMS_TEMP;
            stby_cnt_reg <= 40'(spms_pkg::BASE_CYC) << odr_reg; // RULE10
            conv_start_reg <= temp_en_reg; // RULE15 RULE19
          end
        end
        spms_pkg::SPMS_TEMP: begin
          if (stby_cnt_reg != 40'h00_0000_0000) stby_cnt_reg <= stby_cnt_reg - 40'h00_0000_0001;
          if (!temp_en_reg || conv_done) begin
            state_reg <= spms_pkg::SPMS_PRES;
            conv_start_reg <= press_en_reg; // RULE16
          end
        end
        spms_pkg::SPMS_PRES: begin
          if (stby_cnt_reg != 40'h00_0000_0000) stby_cnt_reg <= stby_cnt_reg - 40'h00_0000_0001;
          if (!press_en_reg || conv_done) begin
            state_reg <= spms_pkg::SPMS_FILT;
            filt_load_reg <= 1'b1; // RULE15
          end
        end
        spms_pkg::SPMS_FILT: begin
          if (stby_cnt_reg != 40'h00_0000_0000) stby_cnt_reg <= stby_cnt_reg - 40'h00_0000_0001;
          state_reg <= (mode_reg == spms_pkg::MODE_NORMAL && !pend_reg) ? spms_pkg::SPMS_STBY
                       : spms_pkg::SPMS_IDLE;
        end
        spms_pkg::SPMS_STBY: begin
          if (mode_reg != spms_pkg::MODE_NORMAL || soft_rst) begin
            state_reg <= spms_pkg::SPMS_IDLE;
          end else if (stby_cnt_reg <= 40'h00_0000_0001) begin
            state_reg <= spms_pkg::SPMS_TEMP; // RULE2
            stby_cnt_reg <= 40'(spms_pkg::BASE_CYC) << odr_reg; // RULE10
            conv_start_reg <= temp_en_reg;
          end else begin
            stby_cnt_reg <= stby_cnt_reg - 40'h00_0000_0001;
          end
        end
        default: state_reg <= spms_pkg::SPMS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data registers: only converted channels update
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      got_p_reg <= 1'b0;
      got_t_reg <= 1'b0;
      pdat_reg <= '0;
      tdat_reg <= '0;
      evt_cnt_reg <= 32'h0000_0000;
    end else begin
      if (conv_done && state_reg == spms_pkg::SPMS_TEMP) got_t_reg <= 1'b1;
      if (conv_done && state_reg == spms_pkg::SPMS_PRES) got_p_reg <= 1'b1;
      if (filt_load_reg) begin // RULE15
        got_p_reg <= 1'b0;
        got_t_reg <= 1'b0;
        if (got_p_reg) pdat_reg <= filt_p; // RULE11 RULE23
        if (got_t_reg) tdat_reg <= filt_t; // RULE23
        evt_cnt_reg <= evt_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // converter and filters
  // ----------------------------------------------------------------
  assign conv_osr = (state_reg == spms_pkg::SPMS_PRES) ? osr_p_reg : osr_t_reg;
  assign conv_adc = (state_reg == spms_pkg::SPMS_PRES) ? adc_press_i : adc_temp_i;

  spms_conv u_conv (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(conv_start_reg),
    .osr_i(conv_osr),
    .adc_i(conv_adc),
    .done_o(conv_done),
    .data_o(conv_data)
  );

  // filter the fresh sample the cycle its conversion finishes; skipped channel keeps its state
  spms_iir u_iir_p (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(iir_clr_reg),
    .load_i(conv_done && state_reg == spms_pkg::SPMS_PRES),
    .coef_i(iir_reg),
    .sample_i(conv_data),
    .filt_o(filt_p)
  );

  spms_iir u_iir_t (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(iir_clr_reg),
    .load_i(conv_done && state_reg == spms_pkg::SPMS_TEMP),
    .coef_i(iir_reg),
    .sample_i(conv_data),
    .filt_o(filt_t)
  );
endmodule : spms_top
`default_nettype wire

// [test/spms_properties.sv]
// Purpose: port-level checks for the sensor power mode sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: watches only the ports of spms_top
`timescale 1ns/1ps
`default_nettype none
module spms_properties (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic meas_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // register bus answer
  // ----------------------------------------
  ready_after_setup_a:
    assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  ready_single_a:
    assert property (pready_o |=> !pready_o) else $error("ready held too long");
  ready_cause_a:
    assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("ready without setup");
  error_with_ready_a:
    assert property (pslverr_o |-> pready_o) else $error("error outside ready");
  unmapped_error_a:
    assert property (psel_i && !penable_i && paddr_i > 8'h24 |=> pslverr_o)
      else $error("unmapped address accepted");
  mapped_ok_a:
    assert property (psel_i && !penable_i && paddr_i <= 8'h24 && paddr_i[1:0] == 2'h0
      |=> !pslverr_o) else $error("mapped address refused");
  id_read_a:
    assert property (psel_i && !penable_i && !pwrite_i && paddr_i == spms_pkg::ADDR_ID
      |=> prdata_o[7:0] == spms_pkg::ID_VALUE) else $error("wrong identifier read");
  // ----------------------------------------
  // reset leaves the sequencer asleep
  // ----------------------------------------
  reset_sleep_a:
    assert property ($rose(rstn_i) |-> !meas_busy_o [*2]) else $error("busy right after reset");
endmodule : spms_properties

bind spms_top spms_properties u_props (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .prdata_o(prdata_o),
  .meas_busy_o(meas_busy_o)
);
`default_nettype wire

// [test/spms_host.sv]
// Purpose: host controller model that speaks the register bus
// Assumes: slave answers with pready, any number of wait cycles
// Notes: released lines show inverted values so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module spms_host (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end
  // ----------------------------------------
  // one transfer: setup, access until ready
  // ----------------------------------------
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : spms_host
`default_nettype wire

// [test/spms_top_bench.sv]
// Purpose: self-checking bench for the sensor power mode sequencer
// Assumes: standby is long, so only the first normal-mode period is seen
// Notes: data checks expect the raw sample bits below the kept width to read back as zero
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module spms_top_bench;
  logic clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, busy, soft_rst;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, ev;
  logic [23:0] adc_t, adc_p;
  logic seen, e;
  int n_errors, n_compared, m;
  spms_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .soft_rst_i(soft_rst),
    .adc_temp_i(adc_t), .adc_press_i(adc_p), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .meas_busy_o(busy));
  spms_host host (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  // busy lags by a cycle, so allow a short window for the start
  task meas();
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(posedge clk_i);
      seen = (busy === 1'b1);
    end
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk_i);
  endtask : meas
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    rd(spms_pkg::ADDR_STAT);
    `CHK(q[0], 1'b1)
    rd(spms_pkg::ADDR_STAT);
    `CHK(q[0], 1'b0)
    rd(spms_pkg::ADDR_PWR);
    `CHK(q, 32'h0000_0000)
    rd(spms_pkg::ADDR_ID);
    `CHK(q[7:0], spms_pkg::ID_VALUE)
    wr(spms_pkg::ADDR_CAL, 32'hA5A5_5A5A);
    rd(spms_pkg::ADDR_CAL);
    `CHK(q, 32'hA5A5_5A5A)
    host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
    `CHK(e, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task t_forced();
    for (m = 1; m < 3; m++) begin
      adc_t <= 24'h12_3456 + 24'(m);
      adc_p <= 24'h65_4321 + 24'(m);
      rd(spms_pkg::ADDR_EVT);
      ev = q;
      wr(spms_pkg::ADDR_PWR, 32'(m << 4) | 32'h0000_0003);
      meas();
      `CHK(seen, 1'b1)
      rd(spms_pkg::ADDR_PWR);
      `CHK(q[5:4], spms_pkg::MODE_SLEEP)
      rd(spms_pkg::ADDR_TDAT);
      `CHK(q[23:0], 24'h12_3400)
      rd(spms_pkg::ADDR_PDAT);
      `CHK(q[23:0], 24'h65_4300)
      rd(spms_pkg::ADDR_EVT);
      `CHK(q, ev + 32'h0000_0001)
    end
    wr(spms_pkg::ADDR_PWR, 32'h0000_0003);
    meas();
    `CHK(seen, 1'b0)
    adc_t <= 24'h77_7700;
    adc_p <= 24'h11_1100;
    wr(spms_pkg::ADDR_PWR, 32'h0000_0012);
    meas();
    rd(spms_pkg::ADDR_PDAT);
    `CHK(q[23:0], 24'h65_4300)
    rd(spms_pkg::ADDR_TDAT);
    `CHK(q[23:0], 24'h77_7700)
    $display("test forced done");
  endtask : t_forced
  task t_osr_iir();
    wr(spms_pkg::ADDR_OSR, 32'h0000_0007);
    rd(spms_pkg::ADDR_OSR);
    `CHK(q[2:0], spms_pkg::OSR_MAX)
    wr(spms_pkg::ADDR_OSR, 32'h0000_0005);
    adc_p <= 24'hFF_FFFF;
    wr(spms_pkg::ADDR_PWR, 32'h0000_0013);
    meas();
    rd(spms_pkg::ADDR_PDAT);
    `CHK(q[23:0], 24'hFF_FFF8)
    wr(spms_pkg::ADDR_OSR, 32'h0000_0000);
    wr(spms_pkg::ADDR_IIR, 32'h0000_0001);
    adc_p <= 24'h10_0000;
    wr(spms_pkg::ADDR_PWR, 32'h0000_0013);
    meas();
    rd(spms_pkg::ADDR_PDAT);
    `CHK(q[23:0], 24'h10_0000)
    adc_p <= 24'h20_0000;
    wr(spms_pkg::ADDR_PWR, 32'h0000_0013);
    meas();
    rd(spms_pkg::ADDR_PDAT);
    `CHK(q[23:0], 24'h18_0000)
    wr(spms_pkg::ADDR_IIR, 32'h0000_007F);
    rd(spms_pkg::ADDR_IIR);
    `CHK(q[6:0], spms_pkg::IIR_MAX)
    wr(spms_pkg::ADDR_IIR, 32'h0000_0000);
    $display("test oversampling and filter done");
  endtask : t_osr_iir
  task t_normal();
    adc_p <= 24'h33_3300;
    wr(spms_pkg::ADDR_PWR, 32'h0000_0033);
    for (int i = 0; i < 60 && busy !== 1'b1; i++) @(posedge clk_i);
    rd(spms_pkg::ADDR_STAT);
    `CHK(q[2], 1'b1)
    wr(spms_pkg::ADDR_PWR, 32'h0000_0003);
    rd(spms_pkg::ADDR_STAT);
    `CHK(q[3], 1'b1)
    wr(spms_pkg::ADDR_PWR, 32'h0000_0013);
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk_i);
    rd(spms_pkg::ADDR_PWR);
    `CHK(q[5:4], spms_pkg::MODE_SLEEP)
    rd(spms_pkg::ADDR_PDAT);
    `CHK(q[23:0], 24'h33_3300)
    repeat (100) @(posedge clk_i);
    `CHK(busy, 1'b0)
    wr(spms_pkg::ADDR_PWR, 32'h0000_0033);
    meas();
    wr(spms_pkg::ADDR_PWR, 32'h0000_0013);
    rd(spms_pkg::ADDR_PWR);
    `CHK(q[5:4], spms_pkg::MODE_NORMAL)
    wr(spms_pkg::ADDR_PWR, 32'h0000_0003);
    soft_rst <= 1'b1;
    repeat (4) @(posedge clk_i);
    soft_rst <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(spms_pkg::ADDR_STAT);
    `CHK(q[0], 1'b1)
    $display("test normal and soft reset done");
  endtask : t_normal
  // ----------------------------------------
  // verdict, main sequence, watchdog
  // ----------------------------------------
  task complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    n_errors = 0;
    n_compared = 0;
    rstn_i = 1'b0;
    soft_rst = 1'b0;
    adc_t = 24'h00_0000;
    adc_p = 24'h00_0000;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_forced();
    t_osr_iir();
    t_normal();
    complete_run();
  end
  // tests need far fewer than 50000 cycles
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end
endmodule : spms_top_bench
`default_nettype wire
